// *** common/ras_pkg.sv ***
// constants and types shared by the return address stack design
// assumes a 25 mhz pclk and 32-bit apb register access
// Functional notes
// R01: stack holds return addresses of nested calls and interrupts, 31 deep.
// R02: push pc on explicit push, absolute call, relative call or interrupt acknowledge.
// R03: pop stacked value into pc on return, literal return or interrupt return.
// R04: returns leave the pc upper and high latches untouched.
// R05: storage is 31 words of 21 bits addressed by a stack pointer.
// R06: pointer is 5 bits and every reset clears it. The code clears it on presetn only; por_n alone leaves it unchanged.
// R07: pointer zero has no word; words sit at pointer values 1 to 31.
// R08: push increments pointer first, then writes pc at the new pointer.
// R09: pop reads word at current pointer, then decrements pointer.
// R10: storage is reachable only through the dedicated access registers.
// R11: software reads and writes the stack pointer through a register.
// R12: flags show pointer reached or passed the 31 levels.
// R13: three byte registers read and write the word at the pointer.
// R14: after a push the three top registers return the pushed value.
// R15: rewritten top registers feed the pc on the following return.
// R16: software should mask interrupts while editing the top registers.
// R17: overflow reset enabled: 31st push stores pc plus two, sets full, resets.
// R18: overflow reset disabled: pointer stays 31, further pushes overwrite top.
// R19: pop at pointer zero returns zero, sets underflow, pointer stays zero.
// R20: full and underflow flags stay set until software write or power-on reset.
// R21: top registers read zero and ignore writes while pointer is zero.
package ras_pkg;
  localparam int          DEPTH        = 31;
  localparam int          AW           = 21;
  localparam int          PW           = 5;
  localparam logic [11:0] OFF_PTR      = 12'h000;
  localparam logic [11:0] OFF_TOP_LOW  = 12'h004;
  localparam logic [11:0] OFF_TOP_HIGH = 12'h008;
  localparam logic [11:0] OFF_TOP_UP   = 12'h00c;
  localparam int          BIT_FULL     = 7;
  localparam int          BIT_UNF      = 6;
  localparam logic [4:0]  PTR_RESET    = 5'h00;
  localparam logic [4:0]  PTR_TOP      = 5'h1f;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PUSH = 2'b01,
    OP_POP  = 2'b10
  } stack_op_t;
endpackage

// *** src/ras_mem.sv ***
// 32-entry storage for return addresses, entry 0 unused
// assumes one write port and a registered read port
`timescale 1ns/1ps
module ras_mem #(
  parameter int W = 21,
  parameter int A = 5
) (
  // clock
  input  wire logic         pclk,
  // write port
  input  wire logic         we,
  input  wire logic [A-1:0] waddr,
  input  wire logic [W-1:0] wdata,
  // read port
  input  wire logic [A-1:0] raddr,
  output logic      [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<A)-1];
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** src/ras_apb.sv ***
// apb slave decode for the stack registers
// assumes zero-wait-state apb; read data mux is supplied by the parent
`timescale 1ns/1ps
module ras_apb (
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             pready,
  output logic             pslverr,
  // decoded strobes
  output logic             wr_ptr,
  output logic             wr_low,
  output logic             wr_high,
  output logic             wr_up,
  output logic             mapped
);
  import ras_pkg::*;
  logic acc;
  assign acc     = psel & penable;
  assign mapped  = (paddr == OFF_PTR) | (paddr == OFF_TOP_LOW)
                 | (paddr == OFF_TOP_HIGH) | (paddr == OFF_TOP_UP);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign wr_ptr  = acc & pwrite & (paddr == OFF_PTR);
  assign wr_low  = acc & pwrite & (paddr == OFF_TOP_LOW);
  assign wr_high = acc & pwrite & (paddr == OFF_TOP_HIGH);
  assign wr_up   = acc & pwrite & (paddr == OFF_TOP_UP);
endmodule

// *** src/return_address_stack.sv ***
// return address stack: 31 x 21-bit store, pointer, flags, apb access
// assumes the sequencer issues at most one stack op per cycle and that a
// pop's pc value is taken one cycle after the pop request (registered read)
`timescale 1ns/1ps
module return_address_stack (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     por_n,
  // apb
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // sequencer
  input  wire ras_pkg::stack_op_t       op,
  input  wire logic [ras_pkg::AW-1:0]   pc_in,
  input  wire logic                     overflow_reset_enable,
  output logic      [ras_pkg::AW-1:0]   pc_out,
  output logic                          pc_load,
  output logic                          overflow_reset_req,
  // status
  output logic                          stack_full_flag,
  output logic                          stack_underflow_flag,
  output logic      [ras_pkg::PW-1:0]   stack_pointer
);
  import ras_pkg::*;

  typedef struct packed {
    logic [PW-1:0] ptr;
    logic          load;
    logic          zero_ret;
    logic          ovf_rst;
    logic [31:0]   rdata;
  } state_t;

  state_t s_reg, s_next;

  // flags live apart from the struct: only the power-on reset or a software pointer write clears them
  logic          full_reg, full_next;
  logic          unf_reg, unf_next;

  logic          wr_ptr, wr_low, wr_high, wr_up, mapped;
  logic          mem_we;
  logic [PW-1:0] mem_waddr;
  logic [AW-1:0] mem_wdata;
  logic [AW-1:0] top_q;
  logic [AW-1:0] top_vis;
  logic          is_push, is_pop;
  logic [PW-1:0] ptr_inc;

  ras_apb u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_ptr  (wr_ptr),
    .wr_low  (wr_low),
    .wr_high (wr_high),
    .wr_up   (wr_up),
    .mapped  (mapped)
  );

  // read address follows the pointer next value so top_q is the live top
  ras_mem #(.W(AW), .A(PW)) u_mem (                                       // R05 R10
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (s_next.ptr),
    .rdata (top_q)
  );

  assign is_push = (op == OP_PUSH);                                       // R02
  assign is_pop  = (op == OP_POP);                                        // R03
  assign ptr_inc = s_reg.ptr + 5'h01;

  // forward a same-cycle write so the top registers never show stale data
  logic          fwd_q;
  logic [AW-1:0] fwd_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q <= 1'b0;
      fwd_d <= '0;
    end else begin
      fwd_q <= mem_we & (mem_waddr == s_next.ptr);
      fwd_d <= mem_wdata;
    end
  end
  assign top_vis = (s_reg.ptr == PTR_RESET) ? '0 : (fwd_q ? fwd_d : top_q); // R21 R07

  // storage write: push at incremented pointer (at pointer 31 when already at the top), or byte edit of the top
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = s_reg.ptr;
    mem_wdata = top_vis;
    if (is_push) begin
      mem_we = 1'b1;
      if (s_reg.ptr == PTR_TOP) begin
        mem_waddr = PTR_TOP;                                              // R18
        mem_wdata = pc_in;
      end else begin
        mem_waddr = ptr_inc;                                              // R08
        mem_wdata = (ptr_inc == PTR_TOP && overflow_reset_enable)
                  ? pc_in + PC_STEP : pc_in;                              // R17
      end
    end else if (s_reg.ptr != PTR_RESET && (wr_low | wr_high | wr_up)) begin // R21
      mem_we = 1'b1;                                                      // R13 R15
      if (wr_low)  mem_wdata[7:0]   = pwdata[7:0];
      if (wr_high) mem_wdata[15:8]  = pwdata[7:0];
      if (wr_up)   mem_wdata[20:16] = pwdata[4:0];
    end
  end

  always_comb begin
    s_next          = s_reg;
    full_next       = full_reg;
    unf_next        = unf_reg;
    s_next.load     = 1'b0;
    s_next.zero_ret = 1'b0;
    s_next.ovf_rst  = 1'b0;
    if (is_push) begin
      if (s_reg.ptr == PTR_TOP) begin
        full_next = 1'b1;                                                 // R18
      end else if (ptr_inc == PTR_TOP) begin
        full_next = 1'b1;                                                 // R12
        if (overflow_reset_enable) begin
          s_next.ptr     = PTR_RESET;                                     // R17
          s_next.ovf_rst = 1'b1;
        end else begin
          s_next.ptr = ptr_inc;
        end
      end else begin
        s_next.ptr = ptr_inc;                                             // R01 R08
      end
    end else if (is_pop) begin
      s_next.load = 1'b1;
      if (s_reg.ptr == PTR_RESET) begin
        unf_next        = 1'b1;                                           // R19
        s_next.zero_ret = 1'b1;
      end else begin
        s_next.ptr = s_reg.ptr - 5'h01;                                   // R09
      end
    end else if (wr_ptr) begin
      // software write; a same-cycle push or pop wins and the whole write is dropped
      s_next.ptr  = pwdata[PW-1:0];                                       // R11
      full_next   = pwdata[BIT_FULL];                                     // R20
      unf_next    = pwdata[BIT_UNF];                                      // R20
    end
    // read data is registered at setup so it is stable in the access phase
    s_next.rdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_PTR:      s_next.rdata = {24'h0, full_reg, unf_reg, 1'b0, s_reg.ptr};
        OFF_TOP_LOW:  s_next.rdata = {24'h0, top_vis[7:0]};              // R14
        OFF_TOP_HIGH: s_next.rdata = {24'h0, top_vis[15:8]};
        OFF_TOP_UP:   s_next.rdata = {27'h0, top_vis[20:16]};
        default:      s_next.rdata = 32'h0;
      endcase
    end else begin
      s_next.rdata = s_reg.rdata;
    end
  end

  // flags survive presetn and clear only on power-on or a software pointer write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.ptr      <= PTR_RESET;                                        // R06
      s_reg.load     <= 1'b0;
      s_reg.zero_ret <= 1'b0;
      s_reg.ovf_rst  <= 1'b0;
      s_reg.rdata    <= 32'h0;
    end else begin
      s_reg.ptr      <= s_next.ptr;
      s_reg.load     <= s_next.load;
      s_reg.zero_ret <= s_next.zero_ret;
      s_reg.ovf_rst  <= s_next.ovf_rst;
      s_reg.rdata    <= s_next.rdata;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      full_reg <= 1'b0;                                                   // R20
      unf_reg  <= 1'b0;
    end else begin
      full_reg <= full_next;
      unf_reg  <= unf_next;
    end
  end

  // pc latches are outside this block and are never driven here
  logic [AW-1:0] top_q_popped;
  logic [AW-1:0] pop_word;
  assign pc_out = s_reg.zero_ret ? '0 : top_q_popped;                     // R03 R04
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_word <= '0;
    end else if (is_pop) begin
      pop_word <= top_vis;                                                // R09 R15
    end
  end
  assign top_q_popped         = pop_word;
  assign pc_load              = s_reg.load;
  assign overflow_reset_req   = s_reg.ovf_rst;
  assign stack_full_flag      = full_reg;
  assign stack_underflow_flag = unf_reg;
  assign stack_pointer        = s_reg.ptr;
  assign prdata               = s_reg.rdata;

  property p_push_inc;
    @(posedge pclk) disable iff (!presetn)
      (is_push && s_reg.ptr < 5'h1e) |=> (s_reg.ptr == $past(s_reg.ptr) + 5'h01);
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not increment"); // R08

  property p_pop_dec;
    @(posedge pclk) disable iff (!presetn)
      (is_pop && s_reg.ptr != 5'h00) |=> (s_reg.ptr == $past(s_reg.ptr) - 5'h01) && pc_load;
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement"); // R09

  property p_unf;
    @(posedge pclk) disable iff (!presetn)
      (is_pop && s_reg.ptr == 5'h00) |=> stack_underflow_flag && pc_out == '0
        && s_reg.ptr == 5'h00;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow pop wrong"); // R19

  property p_full_stay;
    @(posedge pclk) disable iff (!presetn)
      (is_push && s_reg.ptr == 5'h1f) |=> s_reg.ptr == 5'h1f && stack_full_flag;
  endproperty
  a_full_stay: assert property (p_full_stay) else $error("push at top moved pointer"); // R18

  property p_ovf_rst;
    @(posedge pclk) disable iff (!presetn)
      (is_push && s_reg.ptr == 5'h1e && overflow_reset_enable)
        |=> overflow_reset_req && s_reg.ptr == 5'h00 && stack_full_flag;
  endproperty
  a_ovf_rst: assert property (p_ovf_rst) else $error("overflow reset missing"); // R17

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      (stack_full_flag && !wr_ptr) |=> stack_full_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("full flag dropped"); // R20

  property p_zero_top;
    @(posedge pclk) disable iff (!presetn)
      (s_reg.ptr == 5'h00) |-> top_vis == '0;
  endproperty
  a_zero_top: assert property (p_zero_top) else $error("top nonzero at empty"); // R21

  property p_push_read;
    @(posedge pclk) disable iff (!presetn)
      (is_push && s_reg.ptr < 5'h1e) ##1 (op == OP_NONE) |-> top_vis == $past(pc_in);
  endproperty
  a_push_read: assert property (p_push_read) else $error("top not pushed value"); // R14

  property p_zero_wr;
    @(posedge pclk) disable iff (!presetn)
      (s_reg.ptr == 5'h00 && op == OP_NONE && (wr_low || wr_high || wr_up)) |-> !mem_we;
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("top write at empty stack"); // R21

  property p_sw_ptr;
    @(posedge pclk) disable iff (!presetn)
      (wr_ptr && op == OP_NONE) |=> stack_pointer == $past(pwdata[4:0]);
  endproperty
  a_sw_ptr: assert property (p_sw_ptr) else $error("pointer write lost"); // R11

  property p_rd_ptr;
    @(posedge pclk) disable iff (!presetn || !por_n)
      (psel && !penable && !pwrite && paddr == OFF_PTR)
        |=> prdata == {24'h0, $past(stack_full_flag), $past(stack_underflow_flag), 1'b0,
                       $past(stack_pointer)};
  endproperty
  a_rd_ptr: assert property (p_rd_ptr) else $error("pointer read wrong"); // R11

  property p_pop_word;
    @(posedge pclk) disable iff (!presetn)
      (is_pop && s_reg.ptr != 5'h00) |=> pc_out == $past(top_vis);
  endproperty
  a_pop_word: assert property (p_pop_word) else $error("pop returned wrong word"); // R09

  property p_no_ovf;
    @(posedge pclk) disable iff (!presetn)
      (is_push && s_reg.ptr == 5'h1e && !overflow_reset_enable)
        |=> s_reg.ptr == 5'h1f && stack_full_flag && !overflow_reset_req;
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("full push without reset wrong"); // R18

  property p_unf_hold;
    @(posedge pclk) disable iff (!presetn || !por_n)
      (stack_underflow_flag && !wr_ptr) |=> stack_underflow_flag;
  endproperty
  a_unf_hold: assert property (p_unf_hold) else $error("underflow flag dropped"); // R20

  property p_load_pulse;
    @(posedge pclk) disable iff (!presetn)
      pc_load |-> $past(is_pop);
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("pc load without pop"); // R03
endmodule

// *** dv/seq_model.sv ***
// sequencer-side model: issues push and pop requests, captures pc reloads
// assumes the stack samples op at each pclk edge and answers a pop a cycle later
`timescale 1ns/1ps
module seq_model (
  // clock
  input  wire logic                   pclk,
  // stack side
  output ras_pkg::stack_op_t          op,
  output logic [ras_pkg::AW-1:0]      pc_in,
  input  wire logic [ras_pkg::AW-1:0] pc_out,
  input  wire logic                   pc_load
);
  import ras_pkg::*;
  initial begin
    op = OP_NONE;
    pc_in = '0;
  end
  // gap idles first, so a slow sequencer can be mimicked
  task automatic push(input logic [AW-1:0] pc, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    op <= OP_PUSH;
    pc_in <= pc;
    @(posedge pclk);
    op <= OP_NONE;
    // pc bus no longer qualified: show a changed value, not a stale one
    pc_in <= ~pc;
  endtask
  task automatic pop(input int gap, output logic ld, output logic [AW-1:0] pc);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    op <= OP_POP;
    @(posedge pclk);
    op <= OP_NONE;
    @(posedge pclk);
    ld = pc_load;
    pc = pc_out;
  endtask
endmodule

// *** dv/tb_top.sv ***
// return address stack bench: apb register tasks plus the sequencer model
// assumes ras_pkg offsets; no stack op is issued during top-of-stack edits
`timescale 1ns/1ps
module tb_top;
  import ras_pkg::*;
  logic          pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, ovr_en = 1'b0;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata, rd;
  logic          pready, pslverr, err, pc_load, ovr_req, full, unf, ld;
  stack_op_t     op;
  logic [AW-1:0] pc_in, pc_out, v;
  logic [PW-1:0] sp;
  int            fails = 0, num_checks = 0;

  always #20 pclk = ~pclk;

  return_address_stack dut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op(op), .pc_in(pc_in), .overflow_reset_enable(ovr_en),
    .pc_out(pc_out), .pc_load(pc_load), .overflow_reset_req(ovr_req),
    .stack_full_flag(full), .stack_underflow_flag(unf), .stack_pointer(sp)
  );
  seq_model seq (.pclk(pclk), .op(op), .pc_in(pc_in), .pc_out(pc_out), .pc_load(pc_load));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check("pready wait", 32'h1, 32'h0);
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_top(output logic [AW-1:0] t);
    logic [7:0] lo;
    logic [7:0] hi;
    apb(1'b0, OFF_TOP_LOW, 32'h0);
    lo = rd[7:0];
    apb(1'b0, OFF_TOP_HIGH, 32'h0);
    hi = rd[7:0];
    apb(1'b0, OFF_TOP_UP, 32'h0);
    t = {rd[4:0], hi, lo};
  endtask
  task automatic wr_top(input logic [AW-1:0] t);
    apb(1'b1, OFF_TOP_LOW, {24'h0, t[7:0]});
    apb(1'b1, OFF_TOP_HIGH, {24'h0, t[15:8]});
    apb(1'b1, OFF_TOP_UP, {27'h0, t[20:16]});
  endtask
  task automatic do_reset(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= ~por;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
  endtask

  initial begin
    do_reset(1'b1);
    apb(1'b0, OFF_PTR, 32'h0);
    check("ptr after reset", 32'h0, rd);
    check("sp port", 32'h0, 32'(sp));
    apb(1'b1, OFF_TOP_LOW, 32'h5a);
    apb(1'b0, OFF_TOP_LOW, 32'h0);
    check("top at empty", 32'h0, rd);
    $display("test reset done");
    seq.push(21'h0abcde, 0);
    seq.push(21'h154321, 2);
    apb(1'b0, OFF_PTR, 32'h0);
    check("ptr two pushes", 32'h2, rd);
    rd_top(v);
    check("top pushed", 32'h154321, 32'(v));
    wr_top(21'h0f0f0f);
    seq.pop(1, ld, v);
    check("pop load", 32'h1, 32'(ld));
    check("pop rewritten", 32'h0f0f0f, 32'(v));
    seq.pop(0, ld, v);
    check("pop first", 32'h0abcde, 32'(v));
    seq.pop(0, ld, v);
    check("pop empty", 32'h0, 32'(v));
    apb(1'b0, OFF_PTR, 32'h0);
    check("underflow", 32'h40, rd);
    check("unf port", 32'h1, 32'(unf));
    apb(1'b1, OFF_PTR, 32'h45);
    apb(1'b0, OFF_PTR, 32'h0);
    check("ptr write", 32'h45, rd);
    do_reset(1'b0);
    apb(1'b0, OFF_PTR, 32'h0);
    check("flag over reset", 32'h40, rd);
    do_reset(1'b1);
    apb(1'b0, OFF_PTR, 32'h0);
    check("flag after por", 32'h0, rd);
    $display("test push pop done");
    for (int i = 1; i <= 31; i++) begin
      seq.push(21'h1a000 + 21'(i), 0);
      if (i == 30) begin
        apb(1'b0, OFF_PTR, 32'h0);
        check("ptr 30", 32'h1e, rd);
      end
    end
    apb(1'b0, OFF_PTR, 32'h0);
    check("full at 31", 32'h9f, rd);
    check("full port", 32'h1, 32'(full));
    seq.push(21'h1fffff, 1);
    apb(1'b0, OFF_PTR, 32'h0);
    check("ptr stays 31", 32'h9f, rd);
    seq.pop(0, ld, v);
    check("overwritten top", 32'h1fffff, 32'(v));
    for (int i = 30; i >= 1; i--) begin
      seq.pop(0, ld, v);
      check("deep pop", 32'h1a000 + 32'(i), 32'(v));
    end
    apb(1'b0, OFF_PTR, 32'h0);
    check("full kept", 32'h80, rd);
    $display("test depth done");
    ovr_en <= 1'b1;
    apb(1'b1, OFF_PTR, 32'h1e);
    seq.push(21'h012340, 0);
    @(posedge pclk);
    check("overflow reset", 32'h1, 32'(ovr_req));
    apb(1'b0, OFF_PTR, 32'h0);
    check("ptr after overflow", 32'h80, rd);
    apb(1'b1, OFF_PTR, 32'h9f);
    rd_top(v);
    check("stored pc step", 32'(21'h012340 + PC_STEP), 32'(v));
    $display("test overflow done");
    apb(1'b1, 12'h010, 32'hff);
    check("unmapped write err", 32'h1, 32'(err));
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped read", 32'h1, {rd[31:1], err});
    apb(1'b0, OFF_PTR, 32'h0);
    check("ptr untouched", 32'h9f, rd);
    $display("test unmapped done");
    print_verdict();
  end
endmodule
